/* File: sfc_standby_fault_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01 - standby by pin low or config bit 6
// R02 - continuous conversions only when neither standby
// R03 - standby aborts conversion, value registers untouched
// R04 - register reads and writes work in standby
// R05 - pin standby blocks every conversion, single too
// R06 - trigger write in software standby converts both
// R07 - sample open comparator at start, set status 2
// R08 - below-range remote reads as -128 sentinel
// R09 - low limit 80h silences shorted-diode low alarm
// R10 - alert output low on limit or open fault
// R11 - alert release after response address, cause gone
// R12 - single conversion ends back in idle standby
module sfc_standby_fault_ctrl (
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    // pins and analogue front end
    input  wire logic                 low_power_hold_n_i,
    input  wire logic                 open_circuit_i,
    input  wire sfc_pkg::sfc_sample_t local_sample_i,
    input  wire sfc_pkg::sfc_sample_t remote_sample_i,
    // register access from the serial engine
    input  wire sfc_pkg::sfc_reg_wr_t reg_wr_i,
    input  wire logic [7:0]           reg_rd_addr_i,
    input  wire logic                 ara_done_i,
    output logic [7:0]                reg_rd_data_o,
    // results
    output logic [10:0]               local_value_o,
    output logic [10:0]               remote_value_o,
    output logic                      adc_busy_o,
    output logic                      alert_n_o
);
    import sfc_pkg::*;

    // programmable state
    logic [7:0]  config_reg;
    logic [7:0]  remote_low_limit;
    // fault and alert state
    logic        open_flag;
    logic        low_flag;
    logic        alert_latched;
    // sequencer handshake
    logic        single_pending;
    logic        seq_busy;
    logic        seq_start_pulse;
    logic        seq_local_done;
    logic        seq_remote_done;

    // standby decode
    wire sw_standby  = config_reg[CFG_SW_STANDBY_BIT];
    wire hw_standby  = !low_power_hold_n_i;
    wire any_standby = sw_standby || hw_standby;                 // R01
    wire run_normal  = !any_standby;                             // R02

    // single conversion request is honoured only under software standby
    wire trig_hit    = reg_wr_i.wr_en && (reg_wr_i.addr == SINGLE_CONVERSION_TRIGGER_ADDR);
    wire single_ok   = sw_standby && !hw_standby;                // R05
    wire set_single  = trig_hit && single_ok;                    // R06

    // inhibit: pin always kills; config kills unless a single run is in flight
    wire seq_inhibit = hw_standby || (sw_standby && !single_pending);  // R03
    // start: the pending single run is masked in the cycle its remote half
    // completes; the latch clears on that same edge, and without the mask the
    // idle sequencer would see a stale request and launch a second run
    wire seq_start   = run_normal || (single_pending && !seq_remote_done);  // R02
    // the latch drops on completion, on pin standby or on leaving soft standby
    wire single_clear = seq_remote_done || hw_standby || !sw_standby;  // R12

    // remote result with the shorted-diode sentinel
    wire [10:0] remote_code = remote_sample_i.under_range ? REMOTE_SHORT_CODE
                                                           : remote_sample_i.code;  // R08
    // signed compare of upper eight bits against the low limit;
    // the sentinel is -128, so a limit of 80h can never be undercut
    wire remote_below = $signed(remote_code[10:3]) < $signed(remote_low_limit);   // R09

    // write decode; the engine presents each write for a single cycle
    wire cfg_wr = reg_wr_i.wr_en && (reg_wr_i.addr == CONFIG_WR_ADDR);
    wire lim_wr = reg_wr_i.wr_en && (reg_wr_i.addr == REMOTE_LOW_LIMIT_WR_ADDR);
    // any live fault condition, ahead of the alert latch
    wire fault_now   = open_flag || low_flag;
    // release request: ara answered and nothing is faulting any more
    wire alert_clear = ara_done_i && !fault_now;

    // status read data; unused bits read as zero
    wire [7:0] status_rd = (8'h01 << STAT_OPEN_BIT) & {8{open_flag}}
                         | (8'h01 << STAT_REMOTE_LOW_BIT) & {8{low_flag}};
    // read address decode; write-only and unknown addresses read as zero
    wire       rd_cfg       = (reg_rd_addr_i == CONFIG_RD_ADDR);
    wire       rd_status    = (reg_rd_addr_i == STATUS_RD_ADDR);
    wire       rd_limit     = (reg_rd_addr_i == REMOTE_LOW_LIMIT_RD_ADDR);
    wire [7:0] next_rd_data = rd_cfg    ? config_reg
                            : rd_status ? status_rd
                            : rd_limit  ? remote_low_limit
                            : 8'h00;

    // channel sequencer; it aborts in the very cycle inhibit rises
    sfc_conv_seq u_seq (
        .core_clk_i    (core_clk_i),
        .resetn_i      (resetn_i),
        .inhibit_i     (seq_inhibit),
        .start_i       (seq_start),
        .busy_o        (seq_busy),
        .start_pulse_o (seq_start_pulse),
        .local_done_o  (seq_local_done),
        .remote_done_o (seq_remote_done)
    );

    // configuration writes are served in every standby form: the serial
    // engine is the only way back out of software standby apart from reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            config_reg <= CONFIG_RESET;
        end else if (cfg_wr) begin
            config_reg <= reg_wr_i.data;                           // R04
        end
    end

    // remote low limit; an unused, shorted channel is silenced by writing
    // the sentinel code here, so this register must stay writable in standby
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remote_low_limit <= REMOTE_LOW_LIMIT_RESET;
        end else if (lim_wr) begin
            remote_low_limit <= reg_wr_i.data;                     // R04
        end
    end

    // single run latch: a fresh trigger wins over any clear in the same cycle;
    // it also drops on pin standby or when software standby is cleared
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            single_pending <= 1'b0;
        end else if (set_single) begin
            single_pending <= 1'b1;                                // R06
        end else if (single_clear) begin
            single_pending <= 1'b0;                                // R12
        end
    end

    // local value register; a run aborted in its local half never raises the done strobe,
    // so the last good reading survives any standby entry
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            local_value_o <= REMOTE_VALUE_RESET;
        end else if (seq_local_done) begin
            local_value_o <= local_sample_i.code;                  // R03
        end
    end

    // remote value register, sentinel already folded in;
    // written on the same strobe that ends a requested single run
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remote_value_o <= REMOTE_VALUE_RESET;
        end else if (seq_remote_done) begin
            remote_value_o <= remote_code;                         // R12
        end
    end

    // open flag is re-sampled at every start: a repaired diode clears it on
    // the next conversion instead of lingering until a read
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            open_flag <= 1'b0;
        end else if (seq_start_pulse) begin
            open_flag <= open_circuit_i;                           // R07
        end
    end

    // low flag follows each completed remote result against the limit;
    // it only moves on completion, so a limit write acts on the next result
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_flag <= 1'b0;
        end else if (seq_remote_done) begin
            low_flag <= remote_below;                              // R09
        end
    end

    // alert latch: set by any fault, released only after ara with cause gone;
    // set wins so a fault that is still present in the ara cycle holds the pin
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_latched <= 1'b0;
        end else if (fault_now) begin
            alert_latched <= 1'b1;                                 // R10
        end else if (alert_clear) begin
            alert_latched <= 1'b0;                                 // R11
        end
    end

    // read data is registered, so the engine sees it one cycle after the address;
    // the mux ahead of it is purely combinational decode
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rd_data_o <= 8'h00;
        end else begin
            reg_rd_data_o <= next_rd_data;                         // R04
        end
    end

    // busy mirror, one cycle behind the sequencer,
    // so it lags the real converter by one clock on both edges
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            adc_busy_o <= 1'b0;
        end else begin
            adc_busy_o <= seq_busy;
        end
    end

    // alert pin: low from the edge the latch sets until one edge after it clears
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_n_o <= 1'b1;
        end else begin
            alert_n_o <= !(alert_latched || fault_now);            // R10
        end
    end
endmodule

/* File: sfc_pkg.sv */
package sfc_pkg;

    // register offsets seen by the serial bus engine
    localparam logic [7:0] SINGLE_CONVERSION_TRIGGER_ADDR = 8'h0f;
    localparam logic [7:0] CONFIG_RD_ADDR                 = 8'h03;
    localparam logic [7:0] CONFIG_WR_ADDR                 = 8'h09;
    localparam logic [7:0] STATUS_RD_ADDR                 = 8'h02;
    localparam logic [7:0] REMOTE_LOW_LIMIT_RD_ADDR       = 8'h08;
    localparam logic [7:0] REMOTE_LOW_LIMIT_WR_ADDR       = 8'h0e;

    // field positions
    localparam int CFG_SW_STANDBY_BIT = 6;
    localparam int STAT_OPEN_BIT      = 2;
    localparam int STAT_REMOTE_LOW_BIT = 3;

    // reset values
    localparam logic [7:0]  CONFIG_RESET          = 8'h00;
    localparam logic [7:0]  REMOTE_LOW_LIMIT_RESET = 8'h00;
    localparam logic [10:0] REMOTE_VALUE_RESET     = 11'h000;

    // below-range sentinel, -128 degrees in 11-bit form
    localparam logic [10:0] REMOTE_SHORT_CODE = 11'h400;

    // conversion timing: one channel takes this long at 50 ns per cycle
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CHAN_CONV_NS    = 1000;
    localparam int CHAN_CONV_CYC   = (CHAN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CHAN_CONV_LAST = 8'(CHAN_CONV_CYC - 1);

    // register write strobe from the serial engine
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] data;
    } sfc_reg_wr_t;

    // one finished converter sample
    typedef struct packed {
        logic        under_range;
        logic [10:0] code;
    } sfc_sample_t;

endpackage

/* File: sfc_conv_seq.sv */
`timescale 1ns/1ps
// converter sequencer: local then remote, aborted instantly by inhibit
module sfc_conv_seq (
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    // control
    input  wire logic                 inhibit_i,
    input  wire logic                 start_i,
    // completion
    output logic                      busy_o,
    output logic                      start_pulse_o,
    output logic                      local_done_o,
    output logic                      remote_done_o
);
    import sfc_pkg::*;

    typedef enum logic [1:0] {SFC_IDLE, SFC_LOCAL, SFC_REMOTE} sfc_seq_state_t;

    sfc_seq_state_t state;
    sfc_seq_state_t next_state;
    logic [7:0]     cnt;
    wire            cnt_end = (cnt == CHAN_CONV_LAST);

    // next state; inhibit wins so a half-done sample is never committed
    always_comb begin
        next_state = state;
        unique case (state)
            SFC_IDLE:   if (start_i && !inhibit_i) next_state = SFC_LOCAL;
            SFC_LOCAL:  if (inhibit_i) next_state = SFC_IDLE;
                        else if (cnt_end) next_state = SFC_REMOTE;
            SFC_REMOTE: if (inhibit_i || cnt_end) next_state = SFC_IDLE;
        endcase
    end

    // state, counter and completion pulses
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state         <= SFC_IDLE;
            cnt           <= 8'h00;
            start_pulse_o <= 1'b0;
            local_done_o  <= 1'b0;
            remote_done_o <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= (next_state != state || state == SFC_IDLE) ? 8'h00 : cnt + 8'h01;
            start_pulse_o <= (state == SFC_IDLE) && (next_state == SFC_LOCAL);
            local_done_o  <= (state == SFC_LOCAL) && (next_state == SFC_REMOTE);
            remote_done_o <= (state == SFC_REMOTE) && cnt_end && !inhibit_i;
        end
    end

    assign busy_o = (state != SFC_IDLE);
endmodule

/* File: sfc_assertions.sv */
`timescale 1ns/1ps
// watches only the top ports of the standby and fault controller
module sfc_assertions (
    // clock and reset
    input wire logic                 core_clk_i,
    input wire logic                 resetn_i,
    // inputs
    input wire logic                 low_power_hold_n_i,
    input wire logic                 open_circuit_i,
    input wire sfc_pkg::sfc_sample_t local_sample_i,
    input wire sfc_pkg::sfc_sample_t remote_sample_i,
    input wire sfc_pkg::sfc_reg_wr_t reg_wr_i,
    input wire logic [7:0]           reg_rd_addr_i,
    input wire logic                 ara_done_i,
    // outputs
    input wire logic [7:0]           reg_rd_data_o,
    input wire logic [10:0]          local_value_o,
    input wire logic [10:0]          remote_value_o,
    input wire logic                 adc_busy_o,
    input wire logic                 alert_n_o
);
    import sfc_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // open diode held across a conversion start
    sequence open_start;
        open_circuit_i [*3] ##0 $rose(adc_busy_o);
    endsequence
    // busy is one cycle late, so three low cycles leave room for the abort
    chk_pin_idle: assert property ((!low_power_hold_n_i) [*3] |-> !adc_busy_o)
        else $error("converter busy in pin standby");
    chk_pin_hold: assert property ((!low_power_hold_n_i) [*3] |-> $stable(remote_value_o) && $stable(local_value_o))
        else $error("value changed in pin standby");
    chk_start_pin: assert property ($rose(adc_busy_o) |-> $past(low_power_hold_n_i, 2))
        else $error("conversion started with pin low");
    chk_value_busy: assert property ($changed(remote_value_o) || $changed(local_value_o) |-> $past(adc_busy_o))
        else $error("value changed outside a conversion");
    chk_open_alert: assert property (open_start |-> ##[0:4] !alert_n_o)
        else $error("open diode raised no alert");
    // the latch clears on the ara edge and the pin follows one edge later
    chk_alert_release: assert property ($rose(alert_n_o) |-> $past(ara_done_i, 2))
        else $error("alert released without response");
    chk_short_code: assert property ($changed(remote_value_o) && $past(remote_sample_i.under_range)
        |-> remote_value_o == REMOTE_SHORT_CODE)
        else $error("under range not reported as sentinel");
    chk_remote_copy: assert property ($changed(remote_value_o) && !$past(remote_sample_i.under_range)
        |-> remote_value_o == $past(remote_sample_i.code))
        else $error("remote value not the converted code");
endmodule

/* File: sfc_host.sv */
`timescale 1ns/1ps
// serial host stand-in: whole register writes and reads, changed after an edge
module sfc_host (
    // clock
    input  wire logic           core_clk_i,
    // register side
    input  wire logic [7:0]     rd_data_i,
    output sfc_pkg::sfc_reg_wr_t wr_o,
    output logic [7:0]          rd_addr_o
);
    import sfc_pkg::*;
    initial begin
        wr_o = '0;
        rd_addr_o = STATUS_RD_ADDR;
    end
    // released fields show inverted junk so a stale address never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #5;
        wr_o = '{wr_en: 1'b1, addr: a, data: d};
        @(posedge core_clk_i);
        #5;
        wr_o = '{wr_en: 1'b0, addr: ~a, data: ~d};
    endtask
    // read data is registered one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        #5;
        rd_addr_o = a;
        @(posedge core_clk_i);
        #5;
        d = rd_data_i;
    endtask
endmodule

/* File: test_standby_and_sensor_fault_control.sv */
`timescale 1ns/1ps
module test_standby_and_sensor_fault_control;
    import sfc_pkg::*;
    logic        clk, rst_n, hold_n, open_c, ara, busy, alert_n;
    logic [7:0]  rd_addr, rd_data, rd_v;
    logic [10:0] loc_v, rem_v, keep;
    sfc_reg_wr_t wr;
    sfc_sample_t loc_s, rem_s;
    int          err_total, checks_done, cyc, busy_rise, rise0;
    logic [31:0] seed = 32'he57e;
    sfc_standby_fault_ctrl dut (.core_clk_i(clk), .resetn_i(rst_n), .low_power_hold_n_i(hold_n),
        .open_circuit_i(open_c), .local_sample_i(loc_s), .remote_sample_i(rem_s), .reg_wr_i(wr),
        .reg_rd_addr_i(rd_addr), .ara_done_i(ara), .reg_rd_data_o(rd_data), .local_value_o(loc_v),
        .remote_value_o(rem_v), .adc_busy_o(busy), .alert_n_o(alert_n));
    sfc_host host (.core_clk_i(clk), .rd_data_i(rd_data), .wr_o(wr), .rd_addr_o(rd_addr));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // under range always reads back as the sentinel
    function automatic logic [10:0] exp_rem(input sfc_sample_t s);
        return s.under_range ? REMOTE_SHORT_CODE : s.code;
    endfunction
    task automatic roll(input logic ur);
        seed = xs(seed);
        loc_s = '{1'b0, seed[10:0]};
        rem_s = '{ur, {1'b0, seed[25:16]}};
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // counts converter runs, so a stray restart shows up as an extra rise
    always @(posedge busy) busy_rise++;
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, hold_n, open_c, ara, loc_s, rem_s} = {4'b0100, 24'h0};
        repeat (10) @(posedge clk);
        #5;
        rst_n = 1'b1;
        check("alert idle", 11'(alert_n), 11'h1);
        host.rd(CONFIG_RD_ADDR, rd_v);
        check("config reset", 11'(rd_v), 11'(CONFIG_RESET));
        roll(1'b0);
        cycles(100);
        check("remote free run", rem_v, exp_rem(rem_s));
        check("local free run", loc_v, loc_s.code);
        $display("test continuous done");
        keep = exp_rem(rem_s);
        host.wr(CONFIG_WR_ADDR, 8'h40);
        roll(1'b0);
        cycles(100);
        check("remote soft standby", rem_v, keep);
        host.rd(CONFIG_RD_ADDR, rd_v);
        check("config in standby", 11'(rd_v), 11'h040);
        seed = xs(seed);
        rise0 = busy_rise;
        host.wr(SINGLE_CONVERSION_TRIGGER_ADDR, seed[7:0]);
        cycles(60);
        check("remote single", rem_v, exp_rem(rem_s));
        check("local single", loc_v, loc_s.code);
        check("idle after single", 11'(busy), 11'h0);
        check("one run per trigger", 11'(busy_rise - rise0), 11'h1);
        keep = rem_v;
        roll(1'b0);
        cycles(60);
        check("no repeat", rem_v, keep);
        $display("test soft standby done");
        // pin drop part way through the remote half, after the local result is stored
        host.wr(SINGLE_CONVERSION_TRIGGER_ADDR, 8'h00);
        cycles(30);
        hold_n = 1'b0;
        cycles(60);
        check("local before abort", loc_v, loc_s.code);
        check("remote aborted", rem_v, keep);
        host.wr(SINGLE_CONVERSION_TRIGGER_ADDR, 8'hff);
        cycles(60);
        check("pin blocks single", rem_v, keep);
        hold_n = 1'b1;
        $display("test pin standby done");
        open_c = 1'b1;
        roll(1'b1);
        host.wr(SINGLE_CONVERSION_TRIGGER_ADDR, 8'h5a);
        cycles(60);
        check("short sentinel", rem_v, exp_rem(rem_s));
        check("alert on fault", 11'(alert_n), 11'h0);
        host.rd(STATUS_RD_ADDR, rd_v);
        check("open and low flags", 11'(rd_v[3:2]), 11'h3);
        open_c = 1'b0;
        host.wr(REMOTE_LOW_LIMIT_WR_ADDR, 8'h80);
        host.rd(REMOTE_LOW_LIMIT_RD_ADDR, rd_v);
        check("low limit readback", 11'(rd_v), 11'h080);
        host.wr(SINGLE_CONVERSION_TRIGGER_ADDR, 8'h01);
        cycles(60);
        host.rd(STATUS_RD_ADDR, rd_v);
        check("flags cleared", 11'(rd_v[3:2]), 11'h0);
        check("alert held", 11'(alert_n), 11'h0);
        ara = 1'b1;
        cycles(1);
        ara = 1'b0;
        cycles(2);
        check("alert released", 11'(alert_n), 11'h1);
        $display("test sensor fault done");
        test_done();
    end
endmodule
bind sfc_standby_fault_ctrl sfc_assertions chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .low_power_hold_n_i(low_power_hold_n_i), .open_circuit_i(open_circuit_i), .local_sample_i(local_sample_i),
    .remote_sample_i(remote_sample_i), .reg_wr_i(reg_wr_i), .reg_rd_addr_i(reg_rd_addr_i),
    .ara_done_i(ara_done_i), .reg_rd_data_o(reg_rd_data_o), .local_value_o(local_value_o),
    .remote_value_o(remote_value_o), .adc_busy_o(adc_busy_o), .alert_n_o(alert_n_o));
